// file: design/bsr_consts.vh
// Constants for the bit set/clear executor: opcode bytes, fields, state timing.
// Assumes one clock; one clock state of the processor is one enable pulse.
`ifndef BSR_CONSTS_VH
`define BSR_CONSTS_VH
`define BSR_PFX_CB      8'hcb
`define BSR_PFX_IX      8'hdd
`define BSR_PFX_IY      8'hfd
`define BSR_GRP_SET     2'h3
`define BSR_GRP_CLR     2'h2
`define BSR_FLD_MEM     3'h6
`define BSR_FLD_A       3'h7
// Clock cycles per processor state: 1 gives full speed
`define BSR_STATE_DIV   4'h1
`define BSR_FLAG_RST    8'h00
// Clock states of a full, a short and a stretched machine cycle
`define BSR_T_FULL      3'h4
`define BSR_T_SHORT     3'h3
`define BSR_T_LONG      3'h5
`endif

// file: design/bsr_bit_set_reset_execute.v
// Bit set/clear executor: fetches opcode bytes over a simple bus and executes.
// Assumes memory answers a read in the same state that it is requested.
`timescale 1ns/1ns
`include "bsr_consts.vh"
module bsr_bit_set_reset_execute
(
	// Clock and reset
	input  wire        clk,
	input  wire        rst,
	// Start of execution and initial register state
	input  wire        start,
	input  wire [15:0] pcIn,
	input  wire [15:0] ptrPairIn,
	input  wire [15:0] idxOneIn,
	input  wire [15:0] idxTwoIn,
	// Memory bus
	input  wire [7:0]  memRdata,
	output reg  [15:0] memAddr,
	output reg  [7:0]  memWdata,
	output reg         memRd,
	output reg         memWr,
	// Register file view and status
	output reg  [63:0] regFile,
	output reg  [7:0]  flags,
	output reg  [15:0] pcOut,
	output reg         busy,
	output reg         done,
	output reg         badOp,
	output reg  [2:0]  mcycle
);
	localparam S_IDLE = 3'h0, S_OP1 = 3'h1, S_OP2 = 3'h2, S_DISP = 3'h3, S_OP4 = 3'h4,
		S_MRD = 3'h5, S_MWR = 3'h6, S_END = 3'h7;
	reg [2:0]  state_q;
	reg [2:0]  tcnt_q;
	reg [1:0]  idx_q;
	reg [15:0] ea_q;
	reg [7:0]  op_q;
	reg [3:0]  div_q;
	// Divider kept so the state rate can be slowed for slow memory
	wire       tick = (div_q == `BSR_STATE_DIV - 4'h1);

	// Bit-select decode, code n sets bit n with bit 0 the LSB
	function [7:0] bitMask;
		input [2:0] sel;
		begin
			bitMask = 8'h01 << sel;
		end
	endfunction

	// Set or clear the selected bit; group 11 sets, any other group clears
	function [7:0] modify;
		input [7:0] val;
		input [7:0] op;
		begin
			if (op[7:6] == `BSR_GRP_SET)
				modify = val | bitMask(op[5:3]);
			else
				modify = val & ~bitMask(op[5:3]);
		end
	endfunction

	// Clock states of each machine cycle; indexed forms shorten the displacement
	// fetch and stretch the last opcode fetch, plain memory forms end on a short write cycle
	function [2:0] mLen;
		input [2:0] m;
		input       ix;
		begin
			if (ix)
			begin
				case (m)
					3'h2: mLen = `BSR_T_SHORT;
					3'h3: mLen = `BSR_T_LONG;
					3'h5: mLen = `BSR_T_SHORT;
					default: mLen = `BSR_T_FULL;
				endcase
			end
			else if (m == 3'h3)
				mLen = `BSR_T_SHORT;
			else
				mLen = `BSR_T_FULL;
		end
	endfunction

	// Operand register slot; the memory code 110 maps to slot 6, which stays 0
	wire [7:0] curReg = regFile[op_q[2:0]*8 +: 8];
	wire       lastT  = (tcnt_q == mLen(mcycle, idx_q != 2'h0) - 3'h1);

	// One machine-cycle walk per instruction; flags are loaded only by reset
	always @(posedge clk)
	begin
		if (rst)
		begin
			state_q  <= S_IDLE;
			tcnt_q   <= 3'h0;
			idx_q    <= 2'h0;
			ea_q     <= 16'h0000;
			op_q     <= 8'h00;
			div_q    <= 4'h0;
			memAddr  <= 16'h0000;
			memWdata <= 8'h00;
			memRd    <= 1'b0;
			memWr    <= 1'b0;
			regFile  <= 64'h0;
			flags    <= `BSR_FLAG_RST; // never written afterwards
			pcOut    <= 16'h0000;
			busy     <= 1'b0;
			done     <= 1'b0;
			badOp    <= 1'b0;
			mcycle   <= 3'h0;
		end
		else
		begin
			// Strobes are one-cycle pulses unless set again below
			done  <= 1'b0;
			memRd <= 1'b0;
			memWr <= 1'b0;
			div_q <= tick ? 4'h0 : div_q + 4'h1;
			// Index and pointer inputs are read mid-instruction, so they must hold while busy
			if (state_q == S_IDLE)
			begin
				if (start)
				begin
					state_q <= S_OP1;
					pcOut   <= pcIn;
					busy    <= 1'b1;
					badOp   <= 1'b0;
					tcnt_q  <= 3'h0;
					mcycle  <= 3'h0;
					idx_q   <= 2'h0;
				end
			end
			else if (tick)
			begin
				// Clock-state counter; machine cycle lengths follow mLen
				tcnt_q <= lastT ? 3'h0 : tcnt_q + 3'h1;
				if (tcnt_q == 3'h0 && state_q != S_END)
				begin
					// Bus request on the first state of each machine cycle
					memAddr <= (state_q == S_MRD || state_q == S_MWR) ? ea_q : pcOut;
					memRd   <= (state_q != S_MWR);
					memWr   <= (state_q == S_MWR);
					// Write data was latched at the end of the read cycle and stands here
				end
				if (lastT)
				begin
					mcycle <= mcycle + 3'h1;
					case (state_q)
						S_OP1:
						begin
							pcOut <= pcOut + 16'h0001;
							if (memRdata == `BSR_PFX_IX || memRdata == `BSR_PFX_IY)
							begin
								idx_q   <= (memRdata == `BSR_PFX_IX) ? 2'h1 : 2'h2;
								state_q <= S_OP2;
							end
							else if (memRdata == `BSR_PFX_CB)
								state_q <= S_OP4;
							else
							begin
								badOp   <= 1'b1;
								state_q <= S_END;
							end
						end
						S_OP2:
						begin
							pcOut   <= pcOut + 16'h0001;
							badOp   <= (memRdata != `BSR_PFX_CB);
							state_q <= (memRdata == `BSR_PFX_CB) ? S_DISP : S_END;
						end
						S_DISP:
						begin
							pcOut <= pcOut + 16'h0001;
							// Sign-extended displacement on the selected index
							ea_q  <= ((idx_q == 2'h1) ? idxOneIn : idxTwoIn)
								+ {{8{memRdata[7]}}, memRdata};
							state_q <= S_OP4;
						end
						S_OP4:
						begin
							pcOut <= pcOut + 16'h0001;
							op_q  <= memRdata;
							if (memRdata[7] == 1'b0 ||
								(idx_q != 2'h0 && memRdata[2:0] != `BSR_FLD_MEM))
							begin
								// Bit test, rotates and odd indexed forms go elsewhere
								badOp   <= 1'b1;
								state_q <= S_END;
							end
							else if (memRdata[2:0] == `BSR_FLD_MEM)
							begin
								if (idx_q == 2'h0)
									ea_q <= ptrPairIn;
								state_q <= S_MRD;
							end
							else
							begin
								// register form finishes at the end of the fetch
								state_q <= S_END;
							end
						end
						S_MRD:
						begin
							// Capture inside the read cycle; the bus may move on after it
							memWdata <= modify(memRdata, op_q);
							state_q  <= S_MWR; // write-back reuses ea_q
						end
						S_MWR:
							state_q <= S_END;
						default:
							state_q <= S_END;
					endcase
				end
			end
			// Bad opcodes end here too, with no bus write and no register change
			if (state_q == S_END)
			begin
				// Register result applied once, after the fetch that named it
				if (!badOp && op_q[2:0] != `BSR_FLD_MEM && idx_q == 2'h0)
					regFile[op_q[2:0]*8 +: 8] <= modify(curReg, op_q);
				state_q <= S_IDLE;
				busy    <= 1'b0;
				done    <= 1'b1;
			end
		end
	end
endmodule // bsr_bit_set_reset_execute

// file: verification/bsr_mem_model.sv
// Memory model answering the executor's bus, with combinational read data.
// Assumes memAddr and memWdata stand from their request until the next one.
`timescale 1ns/1ns
module bsr_mem_model
(
	// Bus from the executor
	input  wire        clk,
	input  wire [15:0] memAddr,
	input  wire [7:0]  memWdata,
	input  wire        memRd,
	input  wire        memWr,
	output wire [7:0]  memRdata
);
	reg  [7:0] mem [0:65535];
	reg        liveQ = 1'b0;
	wire       live = memRd | liveQ;
	// From a write until the next read request the lines show the inverse, so a late sample is caught
	assign memRdata = live ? mem[memAddr] : ~mem[memAddr];
	always @(posedge clk)
	begin
		if (memWr)
			mem[memAddr] <= memWdata;
		liveQ <= memWr ? 1'b0 : live;
	end
endmodule // bsr_mem_model

// file: verification/bsr_chk.sv
// Checker on the executor's ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
module bsr_chk
(
	// Watched ports
	input wire        clk,
	input wire        rst,
	input wire        start,
	input wire        busy,
	input wire        done,
	input wire        badOp,
	input wire        memRd,
	input wire        memWr,
	input wire [15:0] memAddr,
	input wire [7:0]  memWdata,
	input wire [7:0]  memRdata,
	input wire [7:0]  flags
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	flags_keep_a: assert property (flags == 8'h00) else $error("flags moved");
	rw_excl_a: assert property (!(memRd && memWr)) else $error("rd and wr");
	wr_addr_a: assert property (memWr |-> $stable(memAddr)) else $error("wr addr");
	wr_bit_a: assert property (memWr |-> $countones(memWdata ^ $past(memRdata)) <= 1)
		else $error("wr data");
	done_pulse_a: assert property (done |=> !done) else $error("done long");
	rd_gap_a: assert property (memRd |=> !memRd [*2]) else $error("short cycle");
	wr_ok_a: assert property (memWr |-> busy && !badOp) else $error("stray wr");
	start_take_a: assert property (start && !busy |=> busy) else $error("no start");
endmodule // bsr_chk
bind bsr_bit_set_reset_execute bsr_chk chkI (.clk(clk), .rst(rst), .start(start),
	.busy(busy), .done(done), .badOp(badOp), .memRd(memRd), .memWr(memWr),
	.memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata), .flags(flags));

// file: verification/test_bit_set_reset_execute.sv
// Testbench for the bit set/clear executor with a memory model.
// Assumes the executor's contract timing at one clock per state.
`timescale 1ns/1ns
module test_bit_set_reset_execute;
	reg         clk = 1'b0, rst = 1'b1, start = 1'b0;
	reg  [15:0] pcIn = 16'h0, ptrPairIn = 16'h3000, idxOneIn = 16'h1000, idxTwoIn = 16'h2000;
	wire [15:0] memAddr, pcOut;
	wire [7:0]  memRdata, memWdata, flags;
	wire [63:0] regFile;
	wire [2:0]  mcycle;
	wire        memRd, memWr, busy, done, badOp;
	integer     n_fail = 0, checked = 0, i, r;
	always #5 clk = ~clk;
	bsr_mem_model m (.clk(clk), .memAddr(memAddr), .memWdata(memWdata), .memRd(memRd),
		.memWr(memWr), .memRdata(memRdata));
	bsr_bit_set_reset_execute uut (.clk(clk), .rst(rst), .start(start), .pcIn(pcIn),
		.ptrPairIn(ptrPairIn), .idxOneIn(idxOneIn), .idxTwoIn(idxTwoIn),
		.memRdata(memRdata), .memAddr(memAddr), .memWdata(memWdata), .memRd(memRd),
		.memWr(memWr), .regFile(regFile), .flags(flags), .pcOut(pcOut), .busy(busy),
		.done(done), .badOp(badOp), .mcycle(mcycle));
	task chk(input [63:0] seen, input [63:0] exp, input [47:0] nm);
	begin
		checked = checked + 1;
		if (seen !== exp)
		begin
			n_fail = n_fail + 1;
			$display("[ERR] %0s exp %h seen %h", nm, exp, seen);
		end
	end
	endtask
	task stop_test;
	begin
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	end
	endtask
	// Cycle count zero skips the timing check
	task exec(input [15:0] pc, input [31:0] code, input integer nb, input integer cyc);
	begin
		for (i = 0; i < nb; i = i + 1)
			m.mem[pc + i] = code[8 * (nb - 1 - i) +: 8];
		@(posedge clk);
		pcIn <= pc;
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		i = 0;
		#1;
		while (done !== 1'b1 && i < 60)
		begin
			@(posedge clk);
			#1;
			i = i + 1;
		end
		if (i >= 60)
		begin
			chk(done, 1'b1, "done");
			stop_test;
		end
		chk(flags, 8'h00, "flags");
		chk(busy, 1'b0, "busy");
		if (cyc > 0)
		begin
			chk(i, cyc, "cycles");
			chk(pcOut, pc + nb, "pc");
		end
	end
	endtask
	task t_reg;
	begin
		for (r = 0; r < 8; r = r + 1)
			if (r != 6)
				exec(16'h0100, {16'h0, 8'hcb, 2'b11, r[2:0], r[2:0]}, 2, 9);
		chk(regFile, 64'h8000201008040201, "regs");
		for (r = 0; r < 8; r = r + 1)
			if (r != 6)
				exec(16'h0100, {16'h0, 8'hcb, 2'b10, r[2:0], r[2:0]}, 2, 9);
		chk(regFile, 64'h0, "regs");
		$display("t_reg end");
	end
	endtask
	task t_mem;
	begin
		m.mem[16'h3000] = 8'hff;
		exec(16'h0200, {16'h0, 8'hcb, 8'h9e}, 2, 16);
		chk(m.mem[16'h3000], 8'hf7, "ptr");
		chk(mcycle, 3'h4, "mcyc");
		m.mem[16'h0ffe] = 8'h00;
		exec(16'h0300, {8'hdd, 8'hcb, 8'hfe, 8'hfe}, 4, 24);
		chk(m.mem[16'h0ffe], 8'h80, "idx1");
		chk(mcycle, 3'h6, "mcyc");
		chk(badOp, 1'b0, "okop");
		m.mem[16'h2005] = 8'h00;
		exec(16'h0300, {8'hfd, 8'hcb, 8'h05, 8'hc6}, 4, 24);
		chk(m.mem[16'h2005], 8'h01, "idx2");
		m.mem[16'h1ffb] = 8'hff;
		exec(16'h0300, {8'hfd, 8'hcb, 8'hfb, 8'h86}, 4, 24);
		chk(m.mem[16'h1ffb], 8'hfe, "idx2c");
		m.mem[16'h1000] = 8'h5a;
		exec(16'h0400, {8'hdd, 8'hcb, 8'h00, 8'hc0}, 4, 0);
		chk(badOp, 1'b1, "bad");
		chk(m.mem[16'h1000], 8'h5a, "badmem");
		$display("t_mem end");
	end
	endtask
	task t_bad;
	begin
		exec(16'h0500, 32'h00000000, 1, 0);
		chk(badOp, 1'b1, "badb1");
		exec(16'h0500, 32'h0000dd00, 2, 0);
		chk(badOp, 1'b1, "badb2");
		exec(16'h0500, 32'h0000cb46, 2, 0);
		chk(badOp, 1'b1, "badb4");
		chk(m.mem[16'h3000], 8'hf7, "bmem");
		exec(16'h0100, 32'h0000cb87, 2, 9);
		chk(badOp, 1'b0, "goodop");
		$display("t_bad end");
	end
	endtask
	// Reset in the middle of an indexed instruction, before its write cycle
	task t_rst;
	begin
		exec(16'h0100, 32'h0000cbc7, 2, 9);
		chk(regFile, 64'h0100000000000000, "rega");
		m.mem[16'h0600] = 8'hdd;
		m.mem[16'h0601] = 8'hcb;
		m.mem[16'h0602] = 8'h03;
		m.mem[16'h0603] = 8'hc6;
		m.mem[16'h1003] = 8'h00;
		@(posedge clk);
		pcIn <= 16'h0600;
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		repeat (12) @(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		#1;
		chk(busy, 1'b0, "rbusy");
		chk(regFile, 64'h0, "rregs");
		chk(pcOut, 16'h0000, "rpc");
		chk(mcycle, 3'h0, "rmcyc");
		chk(memWr, 1'b0, "rwr");
		chk(m.mem[16'h1003], 8'h00, "rmem0");
		exec(16'h0600, 32'hddcb03c6, 4, 24);
		chk(m.mem[16'h1003], 8'h01, "rmem");
		$display("t_rst end");
	end
	endtask
	initial
	begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_reg;
		t_mem;
		t_bad;
		t_rst;
		stop_test;
	end
endmodule // test_bit_set_reset_execute
